// File: hdl/epi_pkg.sv
// Constants and types for the external pin interrupt block
package epi_pkg;
   localparam int EPI_AW = 8;
   // Register byte offsets
   localparam logic [EPI_AW-1:0] EPI_OFF_SENSE  = 8'h00;
   localparam logic [EPI_AW-1:0] EPI_OFF_ENABLE = 8'h04;
   localparam logic [EPI_AW-1:0] EPI_OFF_FLAGS  = 8'h08;
   localparam logic [EPI_AW-1:0] EPI_OFF_PCMASK = 8'h0C;
   // Decoded register index
   localparam logic [2:0] EPI_IDX_SENSE  = 3'h0;
   localparam logic [2:0] EPI_IDX_ENABLE = 3'h1;
   localparam logic [2:0] EPI_IDX_FLAGS  = 3'h2;
   localparam logic [2:0] EPI_IDX_PCMASK = 3'h3;
   localparam logic [2:0] EPI_IDX_NONE   = 3'h4;
   // Field positions: bits shared by enable and flag registers, then sense fields and enable mask
   localparam int EPI_BIT_EXT0 = 6;
   localparam int EPI_BIT_EXT1 = 7;
   localparam int EPI_BIT_PC   = 5;
   localparam int EPI_SENSE_W  = 2;
   localparam int EPI_SENSE0_LSB = 0;
   localparam int EPI_SENSE1_LSB = 2;
   localparam logic [7:0] EPI_EN_MASK = 8'hE0;
   // Reset values
   localparam logic [7:0] EPI_RST_SENSE  = 8'h00;
   localparam logic [7:0] EPI_RST_ENABLE = 8'h00;
   localparam logic [7:0] EPI_RST_PCMASK = 8'h00;
   localparam logic [2:0] EPI_RST_FLAGS  = 3'h0;
   // Bus responses
   localparam logic [1:0] EPI_RESP_OKAY   = 2'h0;
   localparam logic [1:0] EPI_RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      EPI_SNS_LOW  = 2'h0,
      EPI_SNS_ANY  = 2'h1,
      EPI_SNS_FALL = 2'h2,
      EPI_SNS_RISE = 2'h3
   } epi_sense_t;

   typedef struct packed {
      logic [EPI_AW-1:0] awaddr;
      logic              awvalid;
      logic [31:0]       wdata;
      logic [3:0]        wstrb;
      logic              wvalid;
      logic              bready;
      logic [EPI_AW-1:0] araddr;
      logic              arvalid;
      logic              rready;
   } epi_axi_in_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } epi_axi_out_t;

   typedef struct packed {
      logic [9:0]        sy1;
      logic [9:0]        sy2;
      logic [9:0]        prev;
      logic [7:0]        sense;
      logic [7:0]        enable;
      logic [7:0]        pcmask;
      logic [2:0]        flag;
      logic              aw_got;
      logic [EPI_AW-1:0] aw_addr;
      logic              w_got;
      logic [7:0]        w_data;
      logic              w_lane0;
      epi_axi_out_t      axo;
      logic [2:0]        irq;
      logic              wake;
   } epi_state_t;
endpackage

// File: hdl/epi_top.sv
// External pin interrupt logic with AXI4-Lite registers
// What this block does
// RULE_01: Pins trigger even when driven as outputs
// RULE_02: Any masked-in pin-change toggle raises shared request
// RULE_03: Pin-change detection works with I/O clock stopped
// RULE_04: Pin one sense: low, change, fall, rise
// RULE_05: Pin zero sense: same four-way encoding
// RULE_06: Level mode requests while pin stays low
// RULE_07: Edge detection needs the running I/O clock
// RULE_08: Low-level detection wakes without I/O clock
// RULE_09: Level gone before start-up: no request
// RULE_10: Pin sampled; pulses over one clock detected
// RULE_11: Source holds low level until instruction ends
// RULE_12: Enable bit 7 plus global flag gates pin one
// RULE_13: Enable bit 6 plus global flag gates pin zero
// RULE_14: Enable bit 5 plus global flag gates pin-change
// RULE_15: Edge flags 7,6 set; cleared by handler or one
// RULE_16: Flag reads cleared while in level mode
// RULE_17: Flag 5 set on change; handler or one clears
// RULE_18: Mask bit counts only with shared enable set
// RULE_19: Compare current and previous sample each clock
`timescale 1ns/1ps
`default_nettype none
module epi_top (
   input  wire logic                 aclk,               // System clock
   input  wire logic                 aresetn,            // Sync reset, low
   input  wire epi_pkg::epi_axi_in_t s_axi_in,           // AXI4-Lite requests
   output var  epi_pkg::epi_axi_out_t s_axi_out,         // AXI4-Lite answers
   input  wire logic                 ext_irq_pin_zero,   // Dedicated pin 0
   input  wire logic                 ext_irq_pin_one,    // Dedicated pin 1
   input  wire logic [7:0]           pin_change_inputs,  // Pin-change pins
   input  wire logic                 core_global_irq_en, // Core global flag
   input  wire logic                 io_clk_run,         // I/O clock running
   input  wire logic [2:0]           irq_taken,          // Vector entered
   output var  logic [2:0]           irq_req,            // Requests to core
   output var  logic                 wake_req            // Wake from sleep
);
   import epi_pkg::*;

   epi_state_t st_r;
   epi_state_t st_nxt;
   logic [2:0] set_ev;
   logic [2:0] clr_sw;
   logic [1:0] lvl_low;
   logic [1:0] lvl_mode;
   logic [7:0] pc_chg;
   logic       pc_en;
   logic       do_wr;
   logic [2:0] wr_idx;
   logic [2:0] rd_idx;
   logic [7:0] rd_val;

   function automatic logic [2:0] epi_decode(input logic [EPI_AW-1:0] a);
      logic [2:0] idx;
      case (a)
         EPI_OFF_SENSE:  idx = EPI_IDX_SENSE;
         EPI_OFF_ENABLE: idx = EPI_IDX_ENABLE;
         EPI_OFF_FLAGS:  idx = EPI_IDX_FLAGS;
         EPI_OFF_PCMASK: idx = EPI_IDX_PCMASK;
         default:        idx = EPI_IDX_NONE;
      endcase
      return idx;
   endfunction

   assign pc_en = st_r.enable[EPI_BIT_PC];
   // Per-pin mask only counts while the shared enable is on
   assign pc_chg = (st_r.sy2[9:2] ^ st_r.prev[9:2]) & st_r.pcmask
                   & {8{pc_en}}; // RULE_18
   // Flag set on any enabled toggle, no I/O clock needed
   assign set_ev[2] = |pc_chg; // RULE_02 RULE_03

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_ext
         logic [1:0] mode;
         logic       now_v;
         logic       old_v;
         logic       edge_v;
         assign mode  = st_r.sense[EPI_SENSE0_LSB + EPI_SENSE_W*g +: EPI_SENSE_W];
         // Synchronised sample against previous sample
         assign now_v = st_r.sy2[g]; // RULE_10 RULE_19
         assign old_v = st_r.prev[g];
         always_comb begin
            case (mode)
               EPI_SNS_ANY:  edge_v = now_v ^ old_v; // RULE_04 RULE_05
               EPI_SNS_FALL: edge_v = old_v & ~now_v;
               EPI_SNS_RISE: edge_v = now_v & ~old_v;
               default:      edge_v = 1'b0;
            endcase
         end
         // Edges only seen while the I/O clock runs
         assign set_ev[g]   = edge_v & io_clk_run; // RULE_07
         assign lvl_mode[g] = (mode == EPI_SNS_LOW);
         // Level path ignores io_clk_run so it can wake the part
         assign lvl_low[g]  = lvl_mode[g] & ~now_v
                              & st_r.enable[EPI_BIT_EXT0 + g]; // RULE_08
      end
   endgenerate

   assign wr_idx = epi_decode(st_r.aw_addr);
   assign rd_idx = epi_decode(s_axi_in.araddr);
   assign do_wr  = st_r.aw_got & st_r.w_got & ~st_r.axo.bvalid;

   always_comb begin
      case (rd_idx)
         EPI_IDX_SENSE:  rd_val = st_r.sense;
         EPI_IDX_ENABLE: rd_val = st_r.enable;
         EPI_IDX_PCMASK: rd_val = st_r.pcmask;
         EPI_IDX_FLAGS: begin
            rd_val = 8'h00;
            // Level-mode flags read zero even right after a mode write
            rd_val[EPI_BIT_EXT1] = st_r.flag[1] & ~lvl_mode[1]; // RULE_16
            rd_val[EPI_BIT_EXT0] = st_r.flag[0] & ~lvl_mode[0];
            rd_val[EPI_BIT_PC]   = st_r.flag[2];
         end
         default:        rd_val = 8'h00;
      endcase
   end

   always_comb begin
      st_nxt = st_r;
      clr_sw = 3'h0;
      // Pins are read as levels, whatever drives them
      st_nxt.sy1 = {pin_change_inputs, ext_irq_pin_one,
                    ext_irq_pin_zero}; // RULE_01
      st_nxt.sy2 = st_r.sy1;
      st_nxt.prev[9:2] = st_r.sy2[9:2];
      // Frozen with the I/O clock, so a level change across a stall is seen on restart
      if (io_clk_run) begin
         st_nxt.prev[1:0] = st_r.sy2[1:0]; // RULE_07
      end

      if (s_axi_in.awvalid && st_r.axo.awready) begin
         st_nxt.aw_got  = 1'b1;
         st_nxt.aw_addr = s_axi_in.awaddr;
      end
      if (s_axi_in.wvalid && st_r.axo.wready) begin
         st_nxt.w_got   = 1'b1;
         st_nxt.w_data  = s_axi_in.wdata[7:0];
         st_nxt.w_lane0 = s_axi_in.wstrb[0];
      end
      if (st_r.axo.bvalid && s_axi_in.bready) begin
         st_nxt.axo.bvalid = 1'b0;
      end
      if (do_wr) begin
         st_nxt.aw_got     = 1'b0;
         st_nxt.w_got      = 1'b0;
         st_nxt.axo.bvalid = 1'b1;
         st_nxt.axo.bresp  = (wr_idx == EPI_IDX_NONE) ?
                             EPI_RESP_SLVERR : EPI_RESP_OKAY;
         if (st_r.w_lane0) begin
            case (wr_idx)
               EPI_IDX_SENSE:  st_nxt.sense  = st_r.w_data;
               EPI_IDX_ENABLE: st_nxt.enable = st_r.w_data & EPI_EN_MASK;
               EPI_IDX_PCMASK: st_nxt.pcmask = st_r.w_data;
               EPI_IDX_FLAGS: begin
                  // Write one to clear
                  clr_sw[1] = st_r.w_data[EPI_BIT_EXT1]; // RULE_15
                  clr_sw[0] = st_r.w_data[EPI_BIT_EXT0];
                  clr_sw[2] = st_r.w_data[EPI_BIT_PC]; // RULE_17
               end
               default: begin
               end
            endcase
         end
      end
      st_nxt.axo.awready = ~st_nxt.aw_got & ~st_nxt.axo.bvalid;
      st_nxt.axo.wready  = ~st_nxt.w_got & ~st_nxt.axo.bvalid;

      if (st_r.axo.rvalid && s_axi_in.rready) begin
         st_nxt.axo.rvalid = 1'b0;
      end
      if (s_axi_in.arvalid && st_r.axo.arready) begin
         st_nxt.axo.rvalid = 1'b1;
         st_nxt.axo.rdata  = {24'h000000, rd_val};
         st_nxt.axo.rresp  = (rd_idx == EPI_IDX_NONE) ?
                             EPI_RESP_SLVERR : EPI_RESP_OKAY;
      end
      st_nxt.axo.arready = ~st_nxt.axo.rvalid;

      // A new event wins over handler or software clear
      st_nxt.flag = (st_r.flag & ~clr_sw & ~irq_taken)
                    | set_ev; // RULE_15 RULE_17
      // Level mode keeps its flag cleared
      st_nxt.flag[1:0] = st_nxt.flag[1:0] & ~lvl_mode; // RULE_16

      // Level requests follow the live pin: a level gone
      // before start-up ends simply leaves no request
      st_nxt.irq[0] = core_global_irq_en & st_r.enable[EPI_BIT_EXT0]
                      & (lvl_mode[0] ? ~st_r.sy2[0]
                                     : st_r.flag[0]); // RULE_06 RULE_09 RULE_13
      st_nxt.irq[1] = core_global_irq_en & st_r.enable[EPI_BIT_EXT1]
                      & (lvl_mode[1] ? ~st_r.sy2[1]
                                     : st_r.flag[1]); // RULE_06 RULE_12
      st_nxt.irq[2] = core_global_irq_en & pc_en & st_r.flag[2]; // RULE_14
      // Wake ignores the global flag and the I/O clock
      st_nxt.wake = (|lvl_low) | (st_r.flag[2] & pc_en); // RULE_03 RULE_08
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r        <= '0;
         st_r.sense  <= EPI_RST_SENSE;
         st_r.enable <= EPI_RST_ENABLE;
         st_r.pcmask <= EPI_RST_PCMASK;
         st_r.flag   <= EPI_RST_FLAGS;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign s_axi_out = st_r.axo;
   assign irq_req   = st_r.irq;
   assign wake_req  = st_r.wake;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   property p_rise0;
      (st_r.sense[1:0] == EPI_SNS_RISE) && io_clk_run
         && !st_r.prev[0] && st_r.sy2[0] |=> st_r.flag[0];
   endproperty
   a_rise0: assert property (p_rise0) // RULE_05
      else $error("rising edge on pin zero did not set its flag");

   property p_fall1;
      (st_r.sense[3:2] == EPI_SNS_FALL) && io_clk_run
         && st_r.prev[1] && !st_r.sy2[1] |=> st_r.flag[1];
   endproperty
   a_fall1: assert property (p_fall1) // RULE_04
      else $error("falling edge on pin one did not set its flag");

   property p_pin_pulse;
      (st_r.sense[1:0] == EPI_SNS_ANY) && io_clk_run
         ##0 $changed(st_r.sy2[0]) |=> st_r.flag[0];
   endproperty
   a_pin_pulse: assert property (p_pin_pulse) // RULE_10
      else $error("toggle on pin zero was missed");

   property p_lvl_req;
      (st_r.sense[1:0] == EPI_SNS_LOW) && !st_r.sy2[0]
         && st_r.enable[EPI_BIT_EXT0] && core_global_irq_en
         |=> irq_req[0];
   endproperty
   a_lvl_req: assert property (p_lvl_req) // RULE_06
      else $error("held low level gave no request");

   property p_lvl_flag;
      (st_r.sense[3:2] == EPI_SNS_LOW) |=> !st_r.flag[1];
   endproperty
   a_lvl_flag: assert property (p_lvl_flag) // RULE_16
      else $error("flag set while pin one in level mode");

   property p_stopped;
      !io_clk_run && !st_r.flag[1] |=> !st_r.flag[1];
   endproperty
   a_stopped: assert property (p_stopped) // RULE_07
      else $error("edge flag set with I/O clock stopped");

   property p_pc_set;
      set_ev[2] |=> st_r.flag[2] ##1 wake_req;
   endproperty
   a_pc_set: assert property (p_pc_set) // RULE_17
      else $error("pin-change flag or wake missing");

   property p_pc_off;
      !pc_en && !st_r.flag[2] |=> !st_r.flag[2];
   endproperty
   a_pc_off: assert property (p_pc_off) // RULE_18
      else $error("pin change flagged while shared enable off");

   property p_pc_toggle;
      (st_r.sy2[2] != st_r.prev[2]) && st_r.pcmask[0] && pc_en
         |=> st_r.flag[2];
   endproperty
   a_pc_toggle: assert property (p_pc_toggle) // RULE_02
      else $error("masked-in toggle gave no pin-change flag");

   property p_gate_pc;
      irq_req[2] |-> $past(core_global_irq_en) && $past(pc_en);
   endproperty
   a_gate_pc: assert property (p_gate_pc) // RULE_14
      else $error("pin-change request without both enables");

   property p_gate1;
      irq_req[1] |-> $past(st_r.enable[EPI_BIT_EXT1]);
   endproperty
   a_gate1: assert property (p_gate1) // RULE_12
      else $error("pin one request without its enable");

   property p_taken;
      irq_taken[0] && !set_ev[0] |=> !st_r.flag[0];
   endproperty
   a_taken: assert property (p_taken) // RULE_15
      else $error("handler entry did not clear pin zero flag");

   property p_wake_lvl;
      |lvl_low |=> wake_req;
   endproperty
   a_wake_lvl: assert property (p_wake_lvl) // RULE_08
      else $error("low level gave no wake");

   property p_gate0;
      irq_req[0] |-> $past(st_r.enable[EPI_BIT_EXT0]) && $past(core_global_irq_en);
   endproperty
   a_gate0: assert property (p_gate0) // RULE_13
      else $error("pin zero request without both enables");

   property p_gie1;
      irq_req[1] |-> $past(core_global_irq_en);
   endproperty
   a_gie1: assert property (p_gie1) // RULE_12
      else $error("pin one request with global flag off");

   property p_lvl_gone;
      (st_r.sense[1:0] == EPI_SNS_LOW) && st_r.sy2[0] |=> !irq_req[0];
   endproperty
   a_lvl_gone: assert property (p_lvl_gone) // RULE_09
      else $error("released low level still requests");

   property p_lvl_req1;
      (st_r.sense[3:2] == EPI_SNS_LOW) && !st_r.sy2[1]
         && st_r.enable[EPI_BIT_EXT1] && core_global_irq_en
         |=> irq_req[1];
   endproperty
   a_lvl_req1: assert property (p_lvl_req1) // RULE_06
      else $error("held low level on pin one gave no request");

   property p_any1;
      (st_r.sense[3:2] == EPI_SNS_ANY) && io_clk_run
         && (st_r.sy2[1] != st_r.prev[1]) |=> st_r.flag[1];
   endproperty
   a_any1: assert property (p_any1) // RULE_04
      else $error("change on pin one did not set its flag");

   property p_fall0;
      (st_r.sense[1:0] == EPI_SNS_FALL) && io_clk_run
         && st_r.prev[0] && !st_r.sy2[0] |=> st_r.flag[0];
   endproperty
   a_fall0: assert property (p_fall0) // RULE_05
      else $error("falling edge on pin zero did not set its flag");

   property p_pc_masked;
      (((st_r.sy2[9:2] ^ st_r.prev[9:2]) & st_r.pcmask) == 8'h00)
         && !st_r.flag[2] |=> !st_r.flag[2];
   endproperty
   a_pc_masked: assert property (p_pc_masked) // RULE_18
      else $error("masked-out toggle set the pin-change flag");

   property p_pc_w1c;
      clr_sw[2] && !set_ev[2] |=> !st_r.flag[2];
   endproperty
   a_pc_w1c: assert property (p_pc_w1c) // RULE_17
      else $error("write one did not clear the pin-change flag");

   property p_pc_wake;
      st_r.flag[2] && pc_en |=> wake_req;
   endproperty
   a_pc_wake: assert property (p_pc_wake) // RULE_03
      else $error("pending pin change gave no wake");

   c_rise: cover property (!st_r.flag[0] ##1 st_r.flag[0]);
   c_pc:   cover property (set_ev[2] ##1 irq_req[2]);
   c_lvl:  cover property (lvl_low[1] ##1 irq_req[1]);
   c_wr:   cover property (s_axi_out.bvalid && s_axi_in.bready);
   c_any:  cover property ((st_r.sense[3:2] == EPI_SNS_ANY) && set_ev[1]);
endmodule
`default_nettype wire

// File: bench/epi_pin_src.sv
// Model of the external sources driving the interrupt pins
`timescale 1ns/1ps
`default_nettype none
module epi_pin_src (
   input  wire logic       aclk, // System clock
   output var  logic       pin0, // Dedicated pin 0
   output var  logic       pin1, // Dedicated pin 1
   output var  logic [7:0] pc    // Pin-change pins
);
   initial begin
      pin0 = 1'b1;
      pin1 = 1'b1;
      pc   = 8'h00;
   end
   // Levels held five clocks, well past sync and request latency
   task automatic drive(input logic p0, input logic p1, input logic [7:0] c);
      @(posedge aclk);
      pin0 <= p0;
      pin1 <= p1;
      pc   <= c;
      repeat (5) @(posedge aclk);
      #1;
   endtask
endmodule
`default_nettype wire

// File: bench/epi_top_tb.sv
// Self-checking bench for the external pin interrupt block
`timescale 1ns/1ps
`default_nettype none
module epi_top_tb;
   import epi_pkg::*;
   logic         aclk;
   logic         aresetn;
   logic         gie;
   logic         iorun;
   logic [2:0]   taken;
   epi_axi_in_t  ai;
   epi_axi_out_t ao;
   logic         p0;
   logic         p1;
   logic [7:0]   pc;
   logic [2:0]   irq;
   logic         wake;
   logic [7:0]   pcv;
   logic         lane0;
   int           errors;
   int           check_count;
   int           cyc;
   int           seed;
   logic [7:0]   offs [4] = '{EPI_OFF_SENSE, EPI_OFF_ENABLE, EPI_OFF_FLAGS, EPI_OFF_PCMASK};

   epi_top i_epi_top (.aclk(aclk), .aresetn(aresetn), .s_axi_in(ai), .s_axi_out(ao),
      .ext_irq_pin_zero(p0), .ext_irq_pin_one(p1), .pin_change_inputs(pc),
      .core_global_irq_en(gie), .io_clk_run(iorun), .irq_taken(taken),
      .irq_req(irq), .wake_req(wake));
   epi_pin_src src (.aclk(aclk), .pin0(p0), .pin1(p1), .pc(pc));

   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      logic [31:0] t;
      t = $random(seed);
      @(posedge aclk);
      ai.awaddr  <= a;
      ai.awvalid <= 1'b1;
      ai.wdata   <= {t[31:8], d};
      ai.wstrb   <= {t[2:0], lane0};
      ai.wvalid  <= 1'b1;
      ai.bready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (ai.awvalid && ao.awready)
            ai.awvalid <= 1'b0;
         if (ai.wvalid && ao.wready)
            ai.wvalid <= 1'b0;
      end while (ao.bvalid !== 1'b1);
      ai.bready <= 1'b0;
      chk("bresp", 32'(er), 32'(ao.bresp));
   endtask

   task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp,
                       input logic [1:0] er);
      @(posedge aclk);
      ai.araddr  <= a;
      ai.arvalid <= 1'b1;
      ai.rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (ai.arvalid && ao.arready)
            ai.arvalid <= 1'b0;
      end while (ao.rvalid !== 1'b1);
      ai.rready <= 1'b0;
      chk(what, exp, ao.rdata);
      chk("rresp", 32'(er), 32'(ao.rresp));
   endtask

   initial begin
      cyc = 0;
      forever begin
         @(posedge aclk);
         cyc++;
         if (cyc >= 20000) begin
            errors++;
            $display("BAD watchdog expected done seen hang");
            finish_test();
         end
      end
   end

   initial begin
      int         f;
      logic       g;
      logic [7:0] v;
      logic [7:0] msk;
      logic [7:0] tog;
      seed = 32'hDC2B;
      errors = 0;
      lane0 = 1'b1;
      check_count = 0;
      aresetn = 1'b0;
      gie = 1'b0;
      iorun = 1'b1;
      taken = 3'h0;
      ai = '0;
      pcv = 8'h00;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      foreach (offs[i]) rchk("reset value", offs[i], 32'h0, EPI_RESP_OKAY);
      rchk("unmapped read", 8'h10, 32'h0, EPI_RESP_SLVERR);
      wr(8'h10, 8'hFF, EPI_RESP_SLVERR);
      v = $random(seed);
      wr(EPI_OFF_SENSE, v, EPI_RESP_OKAY);
      rchk("sense rw", EPI_OFF_SENSE, 32'(v), EPI_RESP_OKAY);
      // Byte lane 0 off: write answered but ignored
      lane0 = 1'b0;
      wr(EPI_OFF_SENSE, ~v, EPI_RESP_OKAY);
      lane0 = 1'b1;
      rchk("strobe off", EPI_OFF_SENSE, {24'h000000, v}, EPI_RESP_OKAY);
      wr(EPI_OFF_PCMASK, ~v, EPI_RESP_OKAY);
      rchk("pcmask rw", EPI_OFF_PCMASK, {24'h000000, ~v}, EPI_RESP_OKAY);
      wr(EPI_OFF_PCMASK, 8'h00, EPI_RESP_OKAY);
      wr(EPI_OFF_ENABLE, 8'hFF, EPI_RESP_OKAY);
      rchk("enable rw", EPI_OFF_ENABLE, 32'(EPI_EN_MASK), EPI_RESP_OKAY);
      $display("register test done");
      // The three edge sense codes on both pins, global flag random
      for (int n = 0; n < 2; n++)
         for (int m = 1; m < 4; m++) begin
            g = $random(seed);
            @(posedge aclk);
            gie <= g;
            wr(EPI_OFF_SENSE, 8'(m << (2 * n)), EPI_RESP_OKAY);
            for (int e = 0; e < 2; e++) begin
               src.drive(n == 0 ? e[0] : 1'b1, n == 1 ? e[0] : 1'b1, pcv);
               f = (m == 1 || m == 2 + e);
               rchk("edge flag", EPI_OFF_FLAGS, 32'(f << (6 + n)), EPI_RESP_OKAY);
               chk("edge irq", 32'(f & g) << n, 32'(irq));
               // Falling-edge flags cleared by handler entry, others by write
               if (f && e == 0) begin
                  @(posedge aclk);
                  taken <= 3'(1 << n);
                  @(posedge aclk);
                  taken <= 3'h0;
               end else if (f) begin
                  wr(EPI_OFF_FLAGS, 8'(1 << (6 + n)), EPI_RESP_OKAY);
               end
            end
         end
      $display("edge test done");
      // A pulse is lost while the I/O clock is stopped
      @(posedge aclk);
      gie <= 1'b1;
      iorun <= 1'b0;
      wr(EPI_OFF_SENSE, 8'h05, EPI_RESP_OKAY);
      src.drive(1'b0, 1'b0, pcv);
      src.drive(1'b1, 1'b1, pcv);
      rchk("stopped flags", EPI_OFF_FLAGS, 32'h0, EPI_RESP_OKAY);
      wr(EPI_OFF_SENSE, 8'h00, EPI_RESP_OKAY);
      src.drive(1'b0, 1'b0, pcv);
      chk("level irq", 32'h3, 32'(irq));
      chk("level wake", 32'h1, 32'(wake));
      rchk("level flags", EPI_OFF_FLAGS, 32'h0, EPI_RESP_OKAY);
      src.drive(1'b1, 1'b1, pcv);
      chk("level released", 32'h0, 32'(irq));
      $display("level test done");
      // Pin-change with random masks and toggles
      for (int k = 0; k < 8; k++) begin
         msk = $random(seed);
         tog = $random(seed);
         g = $random(seed);
         @(posedge aclk);
         gie <= g;
         iorun <= k[0];
         wr(EPI_OFF_PCMASK, msk, EPI_RESP_OKAY);
         wr(EPI_OFF_ENABLE, k == 2 ? 8'hC0 : 8'hE0, EPI_RESP_OKAY);
         pcv = pcv ^ tog;
         src.drive(1'b1, 1'b1, pcv);
         f = (k != 2) && ((msk & tog) != 8'h00);
         rchk("pc flag", EPI_OFF_FLAGS, 32'(f << 5), EPI_RESP_OKAY);
         chk("pc irq", 32'(f & g) << 2, 32'(irq));
         chk("pc wake", 32'(f), 32'(wake));
         if (k[1]) begin
            wr(EPI_OFF_FLAGS, 8'h20, EPI_RESP_OKAY);
         end else begin
            @(posedge aclk);
            taken <= 3'h4;
            @(posedge aclk);
            taken <= 3'h0;
         end
         rchk("pc taken", EPI_OFF_FLAGS, 32'h0, EPI_RESP_OKAY);
      end
      $display("pin change test done");
      finish_test();
   end
endmodule
`default_nettype wire
